/* core/ncfg_memmap.sv */
// Page-addressed configuration memory map of a pushbutton transmitter.
// Assumes the reader side presents one page request per cycle on the
// same clock; press and switch inputs arrive asynchronously from pins.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Page 0x31 byte 0 is 0xE0
// - Header length byte reads 0x0A
// - Structure major version byte reads 0x01
// - Maker identifier split across pages 0x31/0x32
// - Page 0x32 upper bytes hold structure identifier
// - Page 0x33 byte 0 reads revision 0x02
// - End marker 0xFE, rest unused
// - Wide fields stored big-endian
// - Configuration locked until correct PIN
// - Level changes and the move to the user key applied only with apply byte 0x55
// - New PIN active after next press
// - Security byte selects radio mode
// - Switch-defined value 3 refused; above reserved
// - NFC level change blocks switch mode changes
// - Later NFC level writes still accepted
// - Teach permit byte gates switch teach-in
// - Next-teach byte forces teach, then clears
// - Twelve-character product text mirrors identification
// - User key write-only, cleared after copy
// - User key used, rolling counter restarts
// - Pages of four bytes addressed
// - First press after change with apply byte 0x55 only applies
module ncfg_memmap
	import ncfg_pkg::*;
#(
	parameter logic [15:0] MAKER_ID  = 16'h1234,  // Arbitrary value
	parameter logic [23:0] STRUCT_ID = 24'h00ABCD // Arbitrary value
) (
	input  wire logic        clk_sys,         // System clock
	input  wire logic        rst,             // Async reset
	input  wire ncfg_req_t   req,             // Page request
	input  wire logic        unlock,          // Present-PIN strobe
	input  wire logic [31:0] unlock_pin,      // PIN presented
	input  wire logic        press_pin,       // Energy harvester pressed
	input  wire logic        factory_rst_pin, // Factory reset request
	input  wire logic        switch_mode_pin, // Contact switch mode request
	input  wire logic [7:0]  switch_level,    // Level the switch selects
	input  wire logic        telegram_sent,   // Telegram sent this cycle
	output ncfg_rsp_t        rsp,             // Page answer
	output logic             unlocked,        // Configuration area open
	output logic [7:0]       radio_mode,      // Active security level
	output logic             switch_blocked,  // Switch mode change blocked
	output logic             teach_enable,    // Switch may trigger teach
	output logic             force_teach,     // Next telegram next_telegram_teach
	output logic             radio_inhibit,   // Suppress telegram this cycle
	output logic [127:0]     active_key,      // Key securing telegrams
	output logic             use_user_key,    // User key in use
	output logic             counter_restart, // Rolling counter to zero
	output logic [95:0]      ident_product,   // Product text for ident string
	output logic             ident_update     // Ident string refresh pulse
);
	// Shadow registers seen by the reader
	logic [7:0]   apply_changes_flag_reg;     // Apply byte
	logic [31:0]  replacement_access_pin_reg; // Pending PIN
	logic [7:0]   radio_security_level_reg;   // Written level
	logic [7:0]   teach_permit_reg;           // Teach permit
	logic [7:0]   next_telegram_teach_reg;    // Next telegram teach
	logic [127:0] custom_security_key_reg;    // Key staging
	logic [95:0]  product_identifier_text_reg;// Product text
	logic [3:0]   key_written_reg;            // Key pages loaded

	// Internal state
	logic [31:0]  access_pin_reg;   // PIN in force
	logic         unlocked_reg;     // Session open
	logic         pending_reg;      // Change awaiting a press
	logic         pin_pending_reg;  // New PIN written
	logic         lvl_written_reg;  // Level written over NFC
	logic         key_pending_reg;  // User key fully written
	logic [127:0] user_key_reg;     // Internal key copy
	logic [127:0] factory_key_reg;  // Factory key, zero here
	logic [7:0]   radio_mode_reg;   // Applied level
	logic         blocked_reg;      // Switch changes blocked
	logic         use_user_reg;     // User key applied
	logic         restart_reg;      // Counter restart pulse
	logic         inhibit_reg;      // Apply-only press
	logic         ident_upd_reg;    // Ident refresh pulse
	ncfg_rsp_t    rsp_reg;          // Registered answer
	ncfg_state_t  state_reg;        // Apply sequencing

	logic press_rise;  // Press edge
	logic fact_rise;   // Factory reset edge
	logic sw_rise;     // Switch mode edge
	logic in_cfg;      // Page inside configuration area
	logic wr_ok;       // Accepted configuration write
	logic [31:0] rd_word; // Read mux result

	// Pin inputs pass two flops each
	ncfg_sync u_press (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (press_pin),
		.level   (),
		.rise    (press_rise)
	);
	ncfg_sync u_fact (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (factory_rst_pin),
		.level   (),
		.rise    (fact_rise)
	);
	ncfg_sync u_sw (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (switch_mode_pin),
		.level   (),
		.rise    (sw_rise)
	);

	assign in_cfg = (req.page >= NCFG_PG_CFG_LO) &&
		(req.page <= NCFG_PG_CFG_HI);
	assign wr_ok = req.wr && in_cfg && unlocked_reg;
	assign factory_key_reg = '0;

	// Unlock: the old PIN stays in force until a press applies a new one
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			unlocked_reg <= 1'b0;
		end else if (unlock) begin
			unlocked_reg <= (unlock_pin == access_pin_reg);
		end
	end

	// Read mux; header constant, big-endian fields, byte 0 in low bits
	always_comb begin
		rd_word = '0;
		unique case (req.page)
			NCFG_PG_HDR0: rd_word = {MAKER_ID[15:8], NCFG_HDR_VER,
				NCFG_HDR_LEN, NCFG_HDR_START};
			NCFG_PG_HDR1: rd_word = {STRUCT_ID[7:0], STRUCT_ID[15:8],
				STRUCT_ID[23:16], MAKER_ID[7:0]};
			NCFG_PG_HDR2: rd_word = {16'h0000, NCFG_HDR_END,
				NCFG_HDR_REV};
			NCFG_PG_FLAG: rd_word = {24'h000000, apply_changes_flag_reg};
			NCFG_PG_PIN: rd_word = {replacement_access_pin_reg[7:0],
				replacement_access_pin_reg[15:8],
				replacement_access_pin_reg[23:16],
				replacement_access_pin_reg[31:24]};
			NCFG_PG_SEC: rd_word = {8'h00, next_telegram_teach_reg,
				teach_permit_reg, radio_security_level_reg};
			8'h48, 8'h49, 8'h4A: begin
				for (int b = 0; b < 4; b++) begin
					rd_word[b*8 +: 8] = product_identifier_text_reg[
						95 - 8*(4*(req.page - NCFG_PG_PID0) + b) -: 8];
				end
			end
			default: rd_word = '0; // Key pages read zero
		endcase
	end

	// Page answer; configuration refused while locked
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg.ack   <= (req.rd | req.wr) & (~in_cfg | unlocked_reg);
			rsp_reg.nak   <= (req.rd | req.wr) & in_cfg & ~unlocked_reg;
			rsp_reg.rdata <= (req.rd && (!in_cfg || unlocked_reg)) ?
				rd_word : 32'h0;
		end
	end

	// Apply byte and pending PIN
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			apply_changes_flag_reg     <= NCFG_RST_FLAG;
			replacement_access_pin_reg <= NCFG_RST_PIN;
			pin_pending_reg            <= 1'b0;
		end else begin
			if (press_rise && pending_reg) begin
				apply_changes_flag_reg <= NCFG_RST_FLAG;
				pin_pending_reg        <= 1'b0;
			end
			if (wr_ok && req.page == NCFG_PG_FLAG) begin
				apply_changes_flag_reg <= req.wdata[7:0];
			end
			if (wr_ok && req.page == NCFG_PG_PIN) begin
				replacement_access_pin_reg <= {req.wdata[7:0],
					req.wdata[15:8], req.wdata[23:16],
					req.wdata[31:24]};
				pin_pending_reg <= 1'b1;
			end
		end
	end

	// Access PIN changes only on a press while a change is pending
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			access_pin_reg <= NCFG_RST_PIN;
		end else if (press_rise && pending_reg && pin_pending_reg) begin
			access_pin_reg <= replacement_access_pin_reg;
		end
	end

	// Security page; value 3 and reserved codes are refused
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			radio_security_level_reg <= NCFG_RST_SEC;
			teach_permit_reg         <= NCFG_RST_PERMIT;
			next_telegram_teach_reg  <= NCFG_RST_NEXT;
			lvl_written_reg          <= 1'b0;
		end else if (fact_rise) begin
			radio_security_level_reg <= NCFG_RST_SEC;
			teach_permit_reg         <= NCFG_RST_PERMIT;
			next_telegram_teach_reg  <= NCFG_RST_NEXT;
			lvl_written_reg          <= 1'b0;
		end else begin
			// Clear after the teach telegram; a same-cycle write wins
			if (telegram_sent && force_teach) begin
				next_telegram_teach_reg <= NCFG_TEACH_OFF;
			end
			if (wr_ok && req.page == NCFG_PG_SEC) begin
				if (req.wdata[7:0] < NCFG_SEC_SWITCH) begin
					radio_security_level_reg <= req.wdata[7:0];
					lvl_written_reg          <= 1'b1;
				end
				if (req.wdata[15:8] <= NCFG_TEACH_ON) begin
					teach_permit_reg <= req.wdata[15:8];
				end
				if (req.wdata[23:16] <= NCFG_TEACH_ON) begin
					next_telegram_teach_reg <= req.wdata[23:16];
				end
			end
		end
	end

	// Key staging: write-only, cleared once copied
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			custom_security_key_reg <= '0;
			key_written_reg         <= '0;
			key_pending_reg         <= 1'b0;
		end else if (key_written_reg == 4'hF) begin
			custom_security_key_reg <= '0;
			key_written_reg         <= '0;
			key_pending_reg         <= 1'b1;
		end else begin
			// Held until the apply cycle has used it; a new full key wins
			if (state_reg == NCFG_APPLY) begin
				key_pending_reg <= 1'b0;
			end
			if (wr_ok && req.page >= NCFG_PG_KEY0 &&
				req.page <= NCFG_PG_KEY3) begin
				for (int b = 0; b < 4; b++) begin
					custom_security_key_reg[127 - 8*(4*(req.page -
						NCFG_PG_KEY0) + b) -: 8] <= req.wdata[b*8 +: 8];
				end
				key_written_reg[2'(req.page - NCFG_PG_KEY0)] <= 1'b1;
			end
		end
	end

	// Internal key copy
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			user_key_reg <= '0;
		end else if (key_written_reg == 4'hF) begin
			user_key_reg <= custom_security_key_reg;
		end
	end

	// Product text and identification refresh
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			product_identifier_text_reg <= '0;
			ident_upd_reg               <= 1'b0;
		end else begin
			ident_upd_reg <= 1'b0;
			if (wr_ok && req.page >= NCFG_PG_PID0 &&
				req.page <= NCFG_PG_PID2) begin
				for (int b = 0; b < 4; b++) begin
					product_identifier_text_reg[95 - 8*(4*(req.page -
						NCFG_PG_PID0) + b) -: 8] <= req.wdata[b*8 +: 8];
				end
				ident_upd_reg <= 1'b1;
			end
		end
	end

	// Pending change: set by any accepted write, set beats clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pending_reg <= 1'b0;
		end else if (wr_ok) begin
			pending_reg <= 1'b1;
		end else if (press_rise) begin
			pending_reg <= 1'b0;
		end
	end

	// Apply sequencing: first press only loads, next presses transmit
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg   <= NCFG_IDLE;
			inhibit_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				NCFG_IDLE: begin
					inhibit_reg <= 1'b0;
					if (press_rise && pending_reg &&
						apply_changes_flag_reg == NCFG_APPLY_KEY) begin
						state_reg   <= NCFG_APPLY;
						inhibit_reg <= 1'b1;
					end
				end
				NCFG_APPLY: begin
					state_reg <= NCFG_RUN;
				end
				NCFG_RUN: begin
					inhibit_reg <= 1'b0;
					state_reg   <= NCFG_IDLE;
				end
				default: state_reg <= NCFG_IDLE;
			endcase
		end
	end

	// Applied mode, switch blocking and key selection
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			radio_mode_reg <= NCFG_RST_SEC;
			blocked_reg    <= 1'b0;
			use_user_reg   <= 1'b0;
			restart_reg    <= 1'b0;
		end else begin
			restart_reg <= 1'b0;
			if (fact_rise) begin
				radio_mode_reg <= NCFG_RST_SEC;
				blocked_reg    <= 1'b0;
				use_user_reg   <= 1'b0;
			end else if (state_reg == NCFG_APPLY) begin
				if (lvl_written_reg) begin
					radio_mode_reg <= radio_security_level_reg;
					blocked_reg    <= 1'b1;
				end
				if (key_pending_reg) begin
					use_user_reg <= 1'b1;
					restart_reg  <= 1'b1;
				end
			end else if (sw_rise && !blocked_reg) begin
				radio_mode_reg <= switch_level;
			end
		end
	end

	assign rsp             = rsp_reg;
	assign unlocked        = unlocked_reg;
	assign radio_mode      = radio_mode_reg;
	assign switch_blocked  = blocked_reg;
	assign teach_enable    = (teach_permit_reg == NCFG_TEACH_ON);
	assign force_teach     = (next_telegram_teach_reg == NCFG_TEACH_ON);
	assign radio_inhibit   = inhibit_reg;
	assign active_key      = use_user_reg ? user_key_reg : factory_key_reg;
	assign use_user_key    = use_user_reg;
	assign counter_restart = restart_reg;
	assign ident_product   = product_identifier_text_reg;
	assign ident_update    = ident_upd_reg;

	// Locked configuration read is always refused next cycle
	chk_locked_refuse: assert property (@(posedge clk_sys) disable iff (rst)
		(req.rd && in_cfg && !unlocked_reg) |=> rsp.nak && !rsp.ack)
		else $error("locked config access not refused");

	// Header start marker constant
	chk_header_start: assert property (@(posedge clk_sys) disable iff (rst)
		(req.rd && req.page == NCFG_PG_HDR0) |=>
		rsp.rdata[7:0] == 8'hE0 && rsp.rdata[15:8] == 8'h0A)
		else $error("header start or length wrong");

	// End marker and revision
	chk_header_end: assert property (@(posedge clk_sys) disable iff (rst)
		(req.rd && req.page == NCFG_PG_HDR2) |=>
		rsp.rdata == 32'h0000FE02)
		else $error("header end page wrong");

	// Value 3 never stored from a write
	chk_level_refuse: assert property (@(posedge clk_sys) disable iff (rst)
		(wr_ok && req.page == NCFG_PG_SEC && req.wdata[7:0] == 8'h03 &&
		!fact_rise) |=> $stable(radio_security_level_reg))
		else $error("switch-defined level accepted");

	// First key page never reads back
	chk_key_hidden: assert property (@(posedge clk_sys) disable iff (rst)
		(req.rd && req.page == NCFG_PG_KEY0) |=> rsp.rdata == 32'h0)
		else $error("user key readable");

	// PIN unchanged without a press
	chk_pin_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!press_rise |=> $stable(access_pin_reg))
		else $error("access pin changed without press");

	// Blocked switch leaves mode alone
	chk_switch_block: assert property (@(posedge clk_sys) disable iff (rst)
		(sw_rise && blocked_reg && !fact_rise && state_reg != NCFG_APPLY)
		|=> $stable(radio_mode_reg))
		else $error("switch changed blocked mode");

	// Apply press inhibits radio for exactly two cycles
	chk_apply_inhibit: assert property (@(posedge clk_sys) disable iff (rst)
		($rose(inhibit_reg) && state_reg == NCFG_APPLY) |->
		inhibit_reg ##1 inhibit_reg ##1 !inhibit_reg)
		else $error("apply inhibit length wrong");
endmodule
`default_nettype wire

/* core/ncfg_pkg.sv */
// Package for the configuration memory map block: page numbers, field
// values, fixed header values, reset values and shared types.
// Assumes pages of four bytes, byte 0 in bits 7:0 of a page word.
package ncfg_pkg;

	// Page addresses
	localparam logic [7:0] NCFG_PG_HDR0    = 8'h31;
	localparam logic [7:0] NCFG_PG_HDR1    = 8'h32;
	localparam logic [7:0] NCFG_PG_HDR2    = 8'h33;
	localparam logic [7:0] NCFG_PG_FLAG    = 8'h40;
	localparam logic [7:0] NCFG_PG_PIN     = 8'h41;
	localparam logic [7:0] NCFG_PG_SEC     = 8'h42;
	localparam logic [7:0] NCFG_PG_RSV     = 8'h43;
	localparam logic [7:0] NCFG_PG_KEY0    = 8'h44;
	localparam logic [7:0] NCFG_PG_KEY3    = 8'h47;
	localparam logic [7:0] NCFG_PG_PID0    = 8'h48;
	localparam logic [7:0] NCFG_PG_PID2    = 8'h4A;
	localparam logic [7:0] NCFG_PG_CFG_LO  = 8'h40;
	localparam logic [7:0] NCFG_PG_CFG_HI  = 8'h4A;

	// Fixed header bytes
	localparam logic [7:0] NCFG_HDR_START  = 8'hE0;
	localparam logic [7:0] NCFG_HDR_LEN    = 8'h0A;
	localparam logic [7:0] NCFG_HDR_VER    = 8'h01;
	localparam logic [7:0] NCFG_HDR_REV    = 8'h02;
	localparam logic [7:0] NCFG_HDR_END    = 8'hFE;

	// Field values
	localparam logic [7:0] NCFG_APPLY_KEY  = 8'h55;
	localparam logic [7:0] NCFG_SEC_NORMAL = 8'h00;
	localparam logic [7:0] NCFG_SEC_IMPL   = 8'h01;
	localparam logic [7:0] NCFG_SEC_EXPL   = 8'h02;
	localparam logic [7:0] NCFG_SEC_SWITCH = 8'h03;
	localparam logic [7:0] NCFG_TEACH_ON   = 8'h01;
	localparam logic [7:0] NCFG_TEACH_OFF  = 8'h00;

	// Reset values
	localparam logic [7:0]  NCFG_RST_SEC    = 8'h03;
	localparam logic [7:0]  NCFG_RST_PERMIT = 8'h01;
	localparam logic [7:0]  NCFG_RST_NEXT   = 8'h00;
	localparam logic [7:0]  NCFG_RST_FLAG   = 8'h00;
	localparam logic [31:0] NCFG_RST_PIN    = 32'h0000E215;

	// Page access from the reader side
	typedef struct packed {
		logic        rd;   // Page read strobe
		logic        wr;   // Page write strobe
		logic [7:0]  page; // Page address
		logic [31:0] wdata;// Page write data, byte 0 first
	} ncfg_req_t;

	// Answer to a page access
	typedef struct packed {
		logic        ack;  // Access accepted
		logic        nak;  // Access refused
		logic [31:0] rdata;// Page read data
	} ncfg_rsp_t;

	// Latch stage of the application, one press-and-release
	typedef enum logic [1:0] {
		NCFG_IDLE  = 2'b00,
		NCFG_APPLY = 2'b01,
		NCFG_RUN   = 2'b11
	} ncfg_state_t;

endpackage

/* core/ncfg_sync.sv */
// Two-flop synchroniser with a rising-edge pulse after the second flop.
// Assumes an asynchronous input level, active high.
`timescale 1ns/1ps
`default_nettype none
module ncfg_sync (
	input  wire logic clk_sys, // System clock
	input  wire logic rst,     // Async reset
	input  wire logic din,     // Raw level
	output logic      level,   // Synchronised level
	output logic      rise     // One-cycle pulse on rising edge
);
	logic meta_reg; // First stage, read only by the second
	logic sync_reg; // Second stage
	logic last_reg; // Previous second stage for edge detect

	// Two stages, then edge history
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= din;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise  = sync_reg & ~last_reg;
endmodule
`default_nettype wire

/* dv/ncfg_reader.sv */
// Reader-side model: page reads, page writes and PIN presentation.
// Assumes the memory map takes a request on a rising edge and answers
// in the cycle after; all drives land 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module ncfg_reader
	import ncfg_pkg::*;
(
	input  wire logic       clk_sys,   // System clock
	input  wire ncfg_rsp_t  rsp,       // Page answer
	output ncfg_req_t       req,       // Page request
	output logic            unlock,    // PIN strobe
	output logic [31:0]     unlock_pin // PIN presented
);
	int gap = 0; // Idle cycles before each access, for a slow reader

	// Idle at time zero so nothing is taken before the first access
	initial begin
		req = '0;
		unlock = 1'b0;
		unlock_pin = 32'h00000000;
	end

	// One whole page per access; released lines show inverted data
	task automatic xfer(input logic wr, input logic [7:0] pg,
		input logic [31:0] wd, output ncfg_rsp_t r);
		repeat (gap) @(posedge clk_sys);
		@(posedge clk_sys);
		#1;
		req = '{rd: !wr, wr: wr, page: pg, wdata: wd};
		@(posedge clk_sys);
		#1;
		r = rsp;
		req = '{rd: 1'b0, wr: 1'b0, page: ~pg, wdata: ~wd};
	endtask

	// Wide value sent most significant byte first, into byte 0
	task automatic wr_be(input logic [7:0] pg, input logic [31:0] v);
		ncfg_rsp_t r;
		xfer(1'b1, pg, {v[7:0], v[15:8], v[23:16], v[31:24]}, r);
	endtask

	// PIN strobe held for exactly one taking edge
	task automatic present(input logic [31:0] pin);
		@(posedge clk_sys);
		#1;
		unlock = 1'b1;
		unlock_pin = pin;
		@(posedge clk_sys);
		#1;
		unlock = 1'b0;
		unlock_pin = ~pin;
	endtask

	// Header read; valid only with the start marker and the end marker at byte length minus one
	task automatic read_header(output logic ok, output logic [95:0] h);
		ncfg_rsp_t r;
		for (int p = 0; p < 3; p++) begin
			xfer(1'b0, NCFG_PG_HDR0 + 8'(p), 32'h00000000, r);
			h[32*p +: 32] = r.rdata;
		end
		ok = (h[7:0] == NCFG_HDR_START) &&
			(h[8*(h[15:8]-8'h01) +: 8] == NCFG_HDR_END);
	endtask
endmodule
`default_nettype wire

/* dv/ncfg_memmap_tb.sv */
// Self-checking bench for the configuration memory map: header, lock,
// field writes, apply press, key, product text and factory reset.
// Assumes the reader model drives the page side of the block.
`timescale 1ns/1ps
`default_nettype none
module ncfg_memmap_tb;
	import ncfg_pkg::*;
	localparam logic [15:0] MK  = 16'hA5C3;   // Arbitrary maker value
	localparam logic [23:0] SID = 24'h3C5A69; // Arbitrary layout value
	localparam logic [127:0] KEY = 128'h0123456789ABCDEF_FEDCBA9876543210;
	localparam logic [95:0] PT  = "ABCD12345678"; // Product text
	logic         clk_sys, rst, press_pin, factory_rst_pin;
	logic         switch_mode_pin, telegram_sent, unlock, ok;
	logic [7:0]   switch_level, exp_lv;
	logic [31:0]  unlock_pin;
	logic [95:0]  hdr;
	ncfg_req_t    req;
	ncfg_rsp_t    rsp, r;
	logic         unlocked, switch_blocked, teach_enable, force_teach;
	logic         radio_inhibit, use_user_key, counter_restart;
	logic         ident_update, seen_cr, seen_iu;
	logic [7:0]   radio_mode;
	logic [127:0] active_key;
	logic [95:0]  ident_product;
	int           error_cnt = 0;
	int           n_tests = 0;

	ncfg_memmap #(.MAKER_ID(MK), .STRUCT_ID(SID)) uut (
		.clk_sys(clk_sys), .rst(rst), .req(req), .unlock(unlock),
		.unlock_pin(unlock_pin), .press_pin(press_pin),
		.factory_rst_pin(factory_rst_pin),
		.switch_mode_pin(switch_mode_pin), .switch_level(switch_level),
		.telegram_sent(telegram_sent), .rsp(rsp), .unlocked(unlocked),
		.radio_mode(radio_mode), .switch_blocked(switch_blocked),
		.teach_enable(teach_enable), .force_teach(force_teach),
		.radio_inhibit(radio_inhibit), .active_key(active_key),
		.use_user_key(use_user_key), .counter_restart(counter_restart),
		.ident_product(ident_product), .ident_update(ident_update));

	ncfg_reader rdr (.clk_sys(clk_sys), .rsp(rsp), .req(req),
		.unlock(unlock), .unlock_pin(unlock_pin));

	// 10 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// One-cycle pulses are caught here so they cannot slip past a wait
	always @(posedge clk_sys) begin
		if (counter_restart === 1'b1) seen_cr = 1'b1;
		if (ident_update === 1'b1) seen_iu = 1'b1;
	end

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Lets the two-flop pin synchroniser and edge detect settle
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic complete_run;
		$display("checks=%0d mismatches=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Hang guard, well past the 130 or so cycles the tests need
	initial begin
		#500000;
		error_cnt++;
		complete_run;
	end

	initial begin
		{rst, press_pin, factory_rst_pin, switch_mode_pin} = 4'hF;
		{press_pin, factory_rst_pin, switch_mode_pin, telegram_sent} = 4'h0;
		{seen_cr, seen_iu} = 2'b00;
		switch_level = 8'h00;
		repeat (8) @(posedge clk_sys);
		#1 rst = 1'b0;
		chk(radio_mode, NCFG_RST_SEC);
		chk({teach_enable, force_teach}, 2'b10);
		rdr.read_header(ok, hdr);
		chk(ok, 1'b1);
		chk(hdr[31:0], {MK[15:8], 24'h010AE0});
		chk(hdr[63:32], {SID[7:0], SID[15:8], SID[23:16], MK[7:0]});
		chk(hdr[95:64], 32'h0000FE02);
		$display("test header done");
		// Locked area refuses both directions
		rdr.xfer(1'b1, NCFG_PG_SEC, 32'h00000001, r);
		chk({r.ack, r.nak}, 2'b01);
		rdr.present(~NCFG_RST_PIN);
		chk(unlocked, 1'b0);
		rdr.xfer(1'b0, NCFG_PG_SEC, 32'h00000000, r);
		chk({r.nak, r.rdata}, {1'b1, 32'h0});
		rdr.present(NCFG_RST_PIN);
		chk(unlocked, 1'b1);
		rdr.xfer(1'b0, NCFG_PG_SEC, 32'h00000000, r);
		chk({r.ack, r.rdata}, {1'b1, 32'h00000103});
		$display("test lock done");
		// Level codes 0 to 2 stored, value 3 and reserved code 4 refused
		exp_lv = NCFG_RST_SEC;
		rdr.gap = 2;
		for (int v = 0; v < 5; v++) begin
			rdr.xfer(1'b1, NCFG_PG_SEC, {24'hFF0001, 8'(v)}, r);
			if (v < 3) exp_lv = 8'(v);
			rdr.xfer(1'b0, NCFG_PG_SEC, 32'h00000000, r);
			chk(r.rdata, {24'h000001, exp_lv});
		end
		rdr.gap = 0;
		rdr.xfer(1'b1, NCFG_PG_RSV, 32'hFFFFFFFF, r);
		rdr.xfer(1'b0, NCFG_PG_RSV, 32'h00000000, r);
		chk({r.ack, r.rdata}, {1'b1, 32'h0});
		$display("test levels done");
		// Teach controls; next-teach clears after the telegram
		rdr.xfer(1'b1, NCFG_PG_SEC, 32'h00010002, r);
		chk({teach_enable, force_teach}, 2'b01);
		telegram_sent = 1'b1;
		settle(1);
		telegram_sent = 1'b0;
		chk(force_teach, 1'b0);
		rdr.xfer(1'b1, NCFG_PG_SEC, 32'h00000102, r);
		chk(teach_enable, 1'b1);
		$display("test teach done");
		// Key, product text, new PIN, then the apply flag
		for (int p = 0; p < 4; p++)
			rdr.wr_be(NCFG_PG_KEY0 + 8'(p), KEY[127-32*p -: 32]);
		rdr.xfer(1'b0, NCFG_PG_KEY0, 32'h00000000, r);
		chk({r.ack, r.rdata}, {1'b1, 32'h0});
		for (int p = 0; p < 3; p++)
			rdr.wr_be(NCFG_PG_PID0 + 8'(p), PT[95-32*p -: 32]);
		rdr.wr_be(NCFG_PG_PIN, 32'h1357ACE0);
		rdr.present(NCFG_RST_PIN);
		chk(unlocked, 1'b1);
		rdr.xfer(1'b1, NCFG_PG_FLAG, {24'h0, NCFG_APPLY_KEY}, r);
		chk(radio_mode, NCFG_RST_SEC);
		press_pin = 1'b1;
		for (int k = 0; k < 20 && radio_inhibit !== 1'b1; k++) settle(1);
		chk(radio_inhibit, 1'b1);
		// Applied values land one cycle after the inhibit rises
		settle(1);
		chk(radio_inhibit, 1'b1);
		chk({radio_mode, switch_blocked}, {8'h02, 1'b1});
		press_pin = 1'b0;
		settle(10);
		chk(radio_inhibit, 1'b0);
		chk({use_user_key, seen_cr}, 2'b11);
		chk(active_key, KEY);
		chk({ident_product, seen_iu}, {PT, 1'b1});
		// After the press the old PIN fails and the new one opens
		rdr.present(NCFG_RST_PIN);
		chk(unlocked, 1'b0);
		rdr.present(32'h1357ACE0);
		chk(unlocked, 1'b1);
		$display("test apply done");
		// Blocked switch, then factory reset releases it
		switch_mode_pin = 1'b1;
		settle(6);
		chk(radio_mode, 8'h02);
		switch_mode_pin = 1'b0;
		factory_rst_pin = 1'b1;
		settle(6);
		chk({switch_blocked, use_user_key}, 2'b00);
		factory_rst_pin = 1'b0;
		// Switch changes the mode again once unblocked
		switch_level = 8'h01;
		switch_mode_pin = 1'b1;
		settle(6);
		chk(radio_mode, 8'h01);
		switch_mode_pin = 1'b0;
		$display("test factory done");
		complete_run;
	end
endmodule
`default_nettype wire
